// File: rtl/atq_pkg.sv
// Constants for the asynchronous transmit packet queue: register map,
// control quadlet fields, transaction codes and status bit positions.
// Assumes one clock domain and a simple strobe register port.
// Summary of operation
// - Final quadlet queues packet with no further action
// - Arbitrate only once whole packet is stored
// - Transaction code selects the packet format
// - No-data: control, destination, offset or response code
// - Speed code 00/01/10 selects 100/200/400
// - Only retry codes retry1 and retryX supported
// - Quadlet format: fourth quadlet data or byte count
// - Block format: length and extended code, then data
// - Last data quadlet zero-padded to whole quadlet
// - Unformatted: control quadlet dropped, no CRC added
// - Status flags show when a queue accepts quadlets
`default_nettype none

package atq_pkg;

   // ****************************************************************
   // Register map (byte addresses)
   // ****************************************************************
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] OFS_REQUEST_BODY = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_REQUEST_FINAL = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_RESPONSE_BODY = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_RESPONSE_FINAL = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h14;

   // ****************************************************************
   // Control quadlet fields
   // ****************************************************************
   localparam int SPD_LSB = 16;
   localparam int RETRY_LSB = 8;
   localparam int TCODE_LSB = 4;

   localparam logic [1:0] SPD_100 = 2'h0;
   localparam logic [1:0] SPD_200 = 2'h1;
   localparam logic [1:0] SPD_400 = 2'h2;
   localparam logic [1:0] RETRY_ONE = 2'h0;
   localparam logic [1:0] RETRY_X = 2'h1;

   localparam logic [3:0] TC_QWRITE_REQ = 4'h0;
   localparam logic [3:0] TC_BWRITE_REQ = 4'h1;
   localparam logic [3:0] TC_WRITE_RSP = 4'h2;
   localparam logic [3:0] TC_QREAD_REQ = 4'h4;
   localparam logic [3:0] TC_BREAD_REQ = 4'h5;
   localparam logic [3:0] TC_QREAD_RSP = 4'h6;
   localparam logic [3:0] TC_BREAD_RSP = 4'h7;
   localparam logic [3:0] TC_LOCK_REQ = 4'h9;
   localparam logic [3:0] TC_LOCK_RSP = 4'hb;
   localparam logic [3:0] TC_UNFORMATTED = 4'he;

   typedef enum logic [2:0] {
      FMT_NO_DATA,
      FMT_QUADLET,
      FMT_BLOCK,
      FMT_UNFORMATTED,
      FMT_UNKNOWN
   } atq_format_t;

   // ****************************************************************
   // Status and control bits
   // ****************************************************************
   localparam int ST_REQ_SPACE = 0;
   localparam int ST_RSP_SPACE = 1;
   localparam int ST_BUSY = 2;
   localparam int ST_REQ_CNT_LSB = 4;
   localparam int ST_RSP_CNT_LSB = 8;
   localparam int ST_BAD_SPEED = 12;
   localparam int ST_BAD_RETRY = 13;
   localparam int ST_OVERFLOW = 14;
   localparam int ST_BAD_TCODE = 15;
   localparam int CT_ENABLE = 0;
   localparam int CT_RSP_FIRST = 1;
   localparam logic [1:0] CTRL_RESET = 2'h3;

endpackage

`default_nettype wire

// File: rtl/atq_top.sv
// Asynchronous transmit packet queue: a request and a response queue
// filled quadlet by quadlet from a strobe register port, and a send
// engine that arbitrates and streams whole packets to the link core.
// Assumes the link core and the arbiter run on clk; no synchronisers.
//
// Added by the designer: the address map and the address-and-strobe port.
`default_nettype none

// ********************************************************************
// Packet word queue
// ********************************************************************
module atq_fifo #(
   parameter int WIDTH = 33,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PTR_W = $clog2(DEPTH);
   localparam logic [PTR_W:0] FULL_CNT = (PTR_W+1)'(DEPTH);
   localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH-1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PTR_W-1:0] wr_ptr_q;
   logic [PTR_W-1:0] rd_ptr_q;
   logic [PTR_W:0] count_q;
   logic push;
   logic pop;

   // Honest flags straight from the occupancy count
   assign in_ready = (count_q != FULL_CNT);
   assign out_valid = (count_q != '0);
   assign out_data = mem[rd_ptr_q];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Storage has no reset; only pointers define content
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_q] <= in_data;
      end
   end

   // Pointers wrap at any depth, not only powers of two
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= (wr_ptr_q == LAST_PTR) ? '0 : wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= (rd_ptr_q == LAST_PTR) ? '0 : rd_ptr_q + 1'b1;
         end
      end
   end

   // Occupancy
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         count_q <= '0;
      end else if (push && !pop) begin
         count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
         count_q <= count_q - 1'b1;
      end
   end
endmodule

// ********************************************************************
// Transmit queue top
// ********************************************************************
module atq_top
   import atq_pkg::*;
#(
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   // Bus arbitration
   output logic arb_request,
   input wire logic arb_grant,
   // Packet stream to the link core
   output logic tx_valid,
   input wire logic tx_ready,
   output logic [31:0] tx_data,
   output logic tx_last,
   output logic [1:0] tx_speed,
   output logic tx_no_crc
);
   localparam int CNT_W = $clog2(DEPTH) + 1;

   typedef enum logic [1:0] {
      SEND_IDLE,
      SEND_ARB,
      SEND_HEAD,
      SEND_BODY
   } atq_send_t;

   // Format decode, used for the head check and status
   function automatic atq_format_t fmt_of(input logic [3:0] tcode);
      case (tcode)
         TC_QREAD_REQ, TC_WRITE_RSP: fmt_of = FMT_NO_DATA;
         TC_QWRITE_REQ, TC_QREAD_RSP, TC_BREAD_REQ: fmt_of = FMT_QUADLET;
         TC_BWRITE_REQ, TC_BREAD_RSP, TC_LOCK_REQ, TC_LOCK_RSP: fmt_of = FMT_BLOCK;
         TC_UNFORMATTED: fmt_of = FMT_UNFORMATTED;
         default: fmt_of = FMT_UNKNOWN;
      endcase
   endfunction

   atq_send_t state_q;
   logic sel_rsp_q;
   logic loaded_last_q;
   logic [1:0] ctrl_q;
   logic bad_speed_q;
   logic bad_retry_q;
   logic overflow_q;
   logic bad_tcode_q;
   logic [CNT_W-1:0] req_pkts_q;
   logic [CNT_W-1:0] rsp_pkts_q;
   logic [31:0] reg_rdata_q;
   logic arb_request_q;
   logic tx_valid_q;
   logic [31:0] tx_data_q;
   logic tx_last_q;
   logic [1:0] tx_speed_q;
   logic tx_no_crc_q;

   logic req_in_valid;
   logic req_in_ready;
   logic rsp_in_valid;
   logic rsp_in_ready;
   logic req_out_valid;
   logic rsp_out_valid;
   logic [32:0] req_out_data;
   logic [32:0] rsp_out_data;
   logic is_final;
   logic head_valid;
   logic [32:0] head_word;
   logic [3:0] head_tcode;
   logic [1:0] head_speed;
   logic [1:0] head_retry;
   logic pop;
   logic load;
   logic pkt_done;
   logic req_done;
   logic rsp_done;
   logic req_added;
   logic rsp_added;
   logic clr_write;
   logic [31:0] status_word;

   // ****************************************************************
   // Queue writes
   // ****************************************************************
   // Body and final ports share one queue; the flag rides in bit 32
   assign is_final = (reg_addr == OFS_REQUEST_FINAL) || (reg_addr == OFS_RESPONSE_FINAL);
   assign req_in_valid = reg_write && ((reg_addr == OFS_REQUEST_BODY) ||
                                       (reg_addr == OFS_REQUEST_FINAL));
   assign rsp_in_valid = reg_write && ((reg_addr == OFS_RESPONSE_BODY) ||
                                       (reg_addr == OFS_RESPONSE_FINAL));
   assign req_added = req_in_valid && req_in_ready && is_final;
   assign rsp_added = rsp_in_valid && rsp_in_ready && is_final;

   atq_fifo #(.WIDTH(33), .DEPTH(DEPTH)) u_req_fifo (
      .clk(clk),
      .reset(reset),
      .in_valid(req_in_valid),
      .in_ready(req_in_ready),
      .in_data({is_final, reg_wdata}),
      .out_valid(req_out_valid),
      .out_ready(pop && !sel_rsp_q),
      .out_data(req_out_data)
   );

   atq_fifo #(.WIDTH(33), .DEPTH(DEPTH)) u_rsp_fifo (
      .clk(clk),
      .reset(reset),
      .in_valid(rsp_in_valid),
      .in_ready(rsp_in_ready),
      .in_data({is_final, reg_wdata}),
      .out_valid(rsp_out_valid),
      .out_ready(pop && sel_rsp_q),
      .out_data(rsp_out_data)
   );

   // ****************************************************************
   // Head of the selected queue
   // ****************************************************************
   assign head_valid = sel_rsp_q ? rsp_out_valid : req_out_valid;
   assign head_word = sel_rsp_q ? rsp_out_data : req_out_data;
   assign head_tcode = head_word[TCODE_LSB +: 4];
   assign head_speed = head_word[SPD_LSB +: 2];
   assign head_retry = head_word[RETRY_LSB +: 2];

   // Output stage is free or draining, and the last word is not out yet
   assign load = (state_q == SEND_BODY) && head_valid && !loaded_last_q && (!tx_valid_q || tx_ready);
   // Unformatted control quadlet is discarded, never sent
   assign pop = load || ((state_q == SEND_HEAD) && fmt_of(head_tcode) == FMT_UNFORMATTED);
   assign pkt_done = ((state_q == SEND_BODY) && tx_valid_q && tx_ready && tx_last_q) ||
                     ((state_q == SEND_HEAD) && fmt_of(head_tcode) == FMT_UNFORMATTED && head_word[32]);
   assign req_done = pkt_done && !sel_rsp_q;
   assign rsp_done = pkt_done && sel_rsp_q;

   // ****************************************************************
   // Complete packet counts
   // ****************************************************************
   // A packet counts only once its final quadlet is stored
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         req_pkts_q <= '0;
         rsp_pkts_q <= '0;
      end else begin
         if (req_added && !req_done) begin
            req_pkts_q <= req_pkts_q + 1'b1;
         end else if (req_done && !req_added) begin
            req_pkts_q <= req_pkts_q - 1'b1;
         end
         if (rsp_added && !rsp_done) begin
            rsp_pkts_q <= rsp_pkts_q + 1'b1;
         end else if (rsp_done && !rsp_added) begin
            rsp_pkts_q <= rsp_pkts_q - 1'b1;
         end
      end
   end

   // ****************************************************************
   // Send engine
   // ****************************************************************
   // Limitation: a packet longer than the queue depth can never complete
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_q <= SEND_IDLE;
         sel_rsp_q <= 1'b0;
      end else begin
         case (state_q)
            SEND_IDLE: begin
               if (ctrl_q[CT_ENABLE] && (req_pkts_q != '0 || rsp_pkts_q != '0)) begin
                  // Responses go first when asked, else requests lead
                  sel_rsp_q <= (rsp_pkts_q != '0) && (ctrl_q[CT_RSP_FIRST] || req_pkts_q == '0);
                  state_q <= SEND_ARB;
               end
            end
            SEND_ARB: begin
               if (arb_grant) begin
                  state_q <= SEND_HEAD;
               end
            end
            SEND_HEAD: begin
               state_q <= pkt_done ? SEND_IDLE : SEND_BODY;
            end
            SEND_BODY: begin
               if (pkt_done) begin
                  state_q <= SEND_IDLE;
               end
            end
            default: state_q <= SEND_IDLE;
         endcase
      end
   end

   // Arbitration request raised the cycle after SEND_ARB is entered, held until grant
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         arb_request_q <= 1'b0;
      end else begin
         arb_request_q <= (state_q == SEND_ARB) && !arb_grant;
      end
   end

   // Per-packet attributes caught from the control quadlet
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         tx_speed_q <= SPD_100;
         tx_no_crc_q <= 1'b0;
      end else if (state_q == SEND_HEAD) begin
         // Undefined speed falls back to the slowest rate
         tx_speed_q <= (head_speed == SPD_100 || head_speed == SPD_200 ||
                        head_speed == SPD_400) ? head_speed : SPD_100;
         tx_no_crc_q <= (fmt_of(head_tcode) == FMT_UNFORMATTED);
      end
   end

   // Output word register, padding already sits in the stored quadlets
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         tx_valid_q <= 1'b0;
         tx_data_q <= '0;
         tx_last_q <= 1'b0;
         loaded_last_q <= 1'b0;
      end else begin
         if (load) begin
            tx_valid_q <= 1'b1;
            tx_data_q <= head_word[31:0];
            tx_last_q <= head_word[32];
            loaded_last_q <= head_word[32];
         end else if (tx_valid_q && tx_ready) begin
            tx_valid_q <= 1'b0;
            tx_last_q <= 1'b0;
         end
         if (state_q == SEND_HEAD) begin
            loaded_last_q <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // Control and sticky status
   // ****************************************************************
   assign clr_write = reg_write && (reg_addr == OFS_STATUS);

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ctrl_q <= CTRL_RESET;
      end else if (reg_write && reg_addr == OFS_CONTROL) begin
         ctrl_q <= reg_wdata[1:0];
      end
   end

   // Write one to clear; a new event in the same cycle wins
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         bad_speed_q <= 1'b0;
         bad_retry_q <= 1'b0;
         bad_tcode_q <= 1'b0;
         overflow_q <= 1'b0;
      end else begin
         if (state_q == SEND_HEAD && !(head_speed inside {SPD_100, SPD_200, SPD_400})) begin
            bad_speed_q <= 1'b1;
         end else if (clr_write && reg_wdata[ST_BAD_SPEED]) begin
            bad_speed_q <= 1'b0;
         end
         if (state_q == SEND_HEAD && fmt_of(head_tcode) != FMT_UNFORMATTED &&
             head_retry != RETRY_ONE && head_retry != RETRY_X) begin
            bad_retry_q <= 1'b1;
         end else if (clr_write && reg_wdata[ST_BAD_RETRY]) begin
            bad_retry_q <= 1'b0;
         end
         if (state_q == SEND_HEAD && fmt_of(head_tcode) == FMT_UNKNOWN) begin
            bad_tcode_q <= 1'b1;
         end else if (clr_write && reg_wdata[ST_BAD_TCODE]) begin
            bad_tcode_q <= 1'b0;
         end
         // A write to a full queue is dropped and flagged
         if ((req_in_valid && !req_in_ready) || (rsp_in_valid && !rsp_in_ready)) begin
            overflow_q <= 1'b1;
         end else if (clr_write && reg_wdata[ST_OVERFLOW]) begin
            overflow_q <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // Register reads
   // ****************************************************************
   always_comb begin
      status_word = '0;
      status_word[ST_REQ_SPACE] = req_in_ready;
      status_word[ST_RSP_SPACE] = rsp_in_ready;
      status_word[ST_BUSY] = (state_q != SEND_IDLE);
      status_word[ST_REQ_CNT_LSB +: CNT_W] = req_pkts_q;
      status_word[ST_RSP_CNT_LSB +: CNT_W] = rsp_pkts_q;
      status_word[ST_BAD_SPEED] = bad_speed_q;
      status_word[ST_BAD_RETRY] = bad_retry_q;
      status_word[ST_OVERFLOW] = overflow_q;
      status_word[ST_BAD_TCODE] = bad_tcode_q;
   end

   // Queue ports and unmapped addresses read as zero
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         reg_rdata_q <= '0;
      end else if (reg_read) begin
         case (reg_addr)
            OFS_STATUS: reg_rdata_q <= status_word;
            OFS_CONTROL: reg_rdata_q <= {30'h0, ctrl_q};
            default: reg_rdata_q <= '0;
         endcase
      end else begin
         reg_rdata_q <= '0;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign reg_rdata = reg_rdata_q;
   assign arb_request = arb_request_q;
   assign tx_valid = tx_valid_q;
   assign tx_data = tx_data_q;
   assign tx_last = tx_last_q;
   assign tx_speed = tx_speed_q;
   assign tx_no_crc = tx_no_crc_q;
endmodule

`default_nettype wire

// File: test/async_transmit_packet_queue_test.sv
// Self-checking bench for the transmit packet queue: the host side is
// driven here, the far side by atq_link_model. Single 100 MHz clock.
`default_nettype none
module async_transmit_packet_queue_test;
   import atq_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [ADDR_W-1:0] reg_addr = '0;
   logic [31:0] reg_wdata = '0;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic [31:0] reg_rdata;
   logic arb_request, arb_grant, tx_valid, tx_ready, tx_last, tx_no_crc;
   logic [31:0] tx_data;
   logic [1:0] tx_speed;
   logic slow = 1'b0;
   int err_count = 0;
   int num_checks = 0;
   int seed = 11810;
   int npk = 0;
   logic [3:0] tcs[11] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hb, 4'he, 4'h3};
   // ****************************************************************
   // Design, far side and clock
   // ****************************************************************
   atq_top #(.DEPTH(8)) DUT (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .arb_request(arb_request),
      .arb_grant(arb_grant), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last),
      .tx_speed(tx_speed), .tx_no_crc(tx_no_crc));
   atq_link_model m (.clk(clk), .reset(reset), .slow(slow), .arb_request(arb_request), .arb_grant(arb_grant),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last), .tx_speed(tx_speed),
      .tx_no_crc(tx_no_crc));
   always #5 clk = ~clk;
   // ****************************************************************
   // Tasks and functions
   // ****************************************************************
   task automatic chk(string what, logic [32:0] exp, logic [32:0] got);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Strobes last one cycle; a gap cycle keeps drivers race free
   task automatic wr(logic [ADDR_W-1:0] a, logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
      reg_wdata <= ~d;
   endtask
   task automatic rd(logic [ADDR_W-1:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      #1 d = reg_rdata;
   endtask
   // Body words first, final word last
   task automatic load(bit rsp, logic [31:0] q[$]);
      foreach (q[i]) wr((rsp ? OFS_RESPONSE_BODY : OFS_REQUEST_BODY) + ((i == q.size() - 1) ? 8'h04 : 8'h00), q[i]);
   endtask
   task automatic expect_pkt(logic [31:0] q[$], bit unf, logic [1:0] spd);
      npk++;
      for (int k = 0; k < 800 && m.pk < npk; k++) @(posedge clk);
      chk("packets", npk, m.pk);
      for (int i = unf; i < q.size(); i++) chk("word", {i == q.size() - 1, q[i]}, m.got.pop_front());
      chk("residue", 0, m.got.size());
      chk("speed", (spd == 2'h3) ? SPD_100 : spd, m.spd_seen);
      chk("no_crc", unf, m.crc_off_seen);
   endtask
   // Packet in the layout its transaction code asks for
   function automatic void build(logic [3:0] tc, logic [1:0] spd, logic [1:0] rt, int blen, ref logic [31:0] q[$]);
      logic [31:0] w;
      q = {32'(spd) << SPD_LSB | 32'(rt) << RETRY_LSB | 32'(tc) << TCODE_LSB};
      w = $random(seed);
      if (tc == TC_UNFORMATTED) q = {q, w, ~w};
      else q = {q, w, $random(seed)};
      if (tc == TC_QWRITE_REQ || tc == TC_QREAD_RSP) q.push_back($random(seed));
      if (tc == TC_BREAD_REQ) q.push_back({16'(blen), 16'h0});
      if (tc inside {TC_BWRITE_REQ, TC_BREAD_RSP, TC_LOCK_REQ, TC_LOCK_RSP}) begin
         q.push_back({16'(blen), (tc == TC_LOCK_REQ || tc == TC_LOCK_RSP) ? 16'h1 : 16'h0});
         for (int d = 0; d < (blen + 3) / 4; d++) begin
            w = $random(seed);
            if (d == (blen - 1) / 4 && blen % 4 != 0) w = w & ~(32'hffffffff >> (8 * (blen % 4)));
            q.push_back(w);
         end
      end
   endfunction
   task automatic wrap_up;
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // ****************************************************************
   // Main sequence and watchdog
   // ****************************************************************
   initial begin
      #400000;
      err_count++;
      wrap_up();
   end
   initial begin
      logic [31:0] st, q[$];
      logic [3:0] tc;
      logic [1:0] rt;
      repeat (20) @(posedge clk);
      chk("reset_idle", 0, 33'(|{reg_rdata, arb_request, tx_valid, tx_last, tx_no_crc, tx_speed}));
      reset <= 1'b0;
      rd(OFS_STATUS, st);
      chk("status_reset", 32'h3, st);
      rd(OFS_CONTROL, st);
      chk("control_reset", 32'h3, st);
      wr(8'h40, 32'h0);
      rd(OFS_REQUEST_BODY, st);
      chk("queue_port_read", 0, st);
      // Every code once, then random codes; speed follows the loop index, lengths are random except zero at index 1
      for (int i = 0; i < 16; i++) begin
         tc = (i < 11) ? tcs[i] : tcs[$unsigned($random(seed)) % 11];
         rt = (i == 3) ? 2'h2 : 2'(i % 2);
         slow <= i[0];
         build(tc, 2'(i), rt, (i == 1) ? 0 : $unsigned($random(seed)) % 17, q);
         load(tc inside {TC_WRITE_RSP, TC_QREAD_RSP, TC_BREAD_RSP, TC_LOCK_RSP}, q);
         expect_pkt(q, tc == TC_UNFORMATTED, 2'(i));
         rd(OFS_STATUS, st);
         chk("bad_speed", 2'(i) == 2'h3, st[ST_BAD_SPEED]);
         chk("bad_retry", rt > 2'h1 && tc != TC_UNFORMATTED, st[ST_BAD_RETRY]);
         chk("bad_tcode", tc == 4'h3, st[ST_BAD_TCODE]);
         wr(OFS_STATUS, 32'hf000);
      end
      // Sending off: fill to depth, overflow, then drain with stalls
      wr(OFS_CONTROL, 32'h0);
      build(TC_BWRITE_REQ, SPD_200, RETRY_X, 16, q);
      load(0, q);
      rd(OFS_STATUS, st);
      chk("full_count", {1'b0, 4'h1, 1'b0}, {st[ST_OVERFLOW], st[ST_REQ_CNT_LSB+:4], st[ST_REQ_SPACE]});
      chk("no_arb_disabled", 0, arb_request);
      wr(OFS_REQUEST_BODY, 32'h5a5a0000);
      rd(OFS_STATUS, st);
      chk("overflow", 1, st[ST_OVERFLOW]);
      slow <= 1'b1;
      wr(OFS_CONTROL, 32'h3);
      expect_pkt(q, 0, SPD_200);
      wrap_up();
   end
endmodule
`default_nettype wire

// File: test/atq_link_model.sv
// Behavioural arbiter and link core that take the packet stream.
// Assumes the same clock as the queue; slow mode stalls at random.
`default_nettype none
module atq_link_model (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Behaviour select
   input wire logic slow,
   // Arbitration
   input wire logic arb_request,
   output logic arb_grant,
   // Packet stream
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic [31:0] tx_data,
   input wire logic tx_last,
   input wire logic [1:0] tx_speed,
   input wire logic tx_no_crc
);
   timeunit 1ns;
   timeprecision 1ps;
   int seed = 7;
   int pk = 0;
   logic [32:0] got[$];
   logic [1:0] spd_seen;
   logic crc_off_seen;
   // ****************************************************************
   // Grant pulse and ready, late and gappy when slow
   // ****************************************************************
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         arb_grant <= 1'b0;
         tx_ready <= 1'b0;
      end else begin
         arb_grant <= arb_request && !arb_grant && (!slow || $random(seed) % 3 == 0);
         tx_ready <= !slow || $random(seed) % 2 == 0;
      end
   end
   // Record every accepted word with its last flag
   always @(posedge clk) begin
      if (!reset && tx_valid && tx_ready) begin
         got.push_back({tx_last, tx_data});
         if (tx_last) begin
            spd_seen = tx_speed;
            crc_off_seen = tx_no_crc;
            pk++;
         end
      end
   end
endmodule
`default_nettype wire

// File: test/atq_properties.sv
// Port-level timing checks for the transmit packet queue top.
// Assumes it is bound onto atq_top: one clock, asynchronous high reset.
`default_nettype none
module atq_properties
   import atq_pkg::*;
#(
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [31:0] reg_rdata,
   // Arbitration and stream
   input wire logic arb_request,
   input wire logic arb_grant,
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire logic [31:0] tx_data,
   input wire logic tx_last,
   input wire logic [1:0] tx_speed,
   input wire logic tx_no_crc
);
   // ****************************************************************
   // Helper: packets finished by the host but not yet sent
   // ****************************************************************
   logic [3:0] pend_q;
   logic fin;
   logic done;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // Final writes add a packet, an accepted last word removes one
   assign fin = reg_write && (reg_addr == OFS_REQUEST_FINAL || reg_addr == OFS_RESPONSE_FINAL);
   assign done = tx_valid && tx_ready && tx_last;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pend_q <= 4'h0;
      end else begin
         pend_q <= pend_q + 4'(fin) - 4'(done);
      end
   end
   // ****************************************************************
   // Assertions
   // ****************************************************************
   sequence s_granted;
      arb_request && arb_grant;
   endsequence
   sequence s_last_taken;
      tx_valid && tx_ready && tx_last;
   endsequence
   chk_rdata_one_cycle: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
      else $error("read data outside its cycle");
   chk_arb_whole_pkt: assert property ($rose(arb_request) |-> pend_q != 4'h0)
      else $error("arbitration without a stored packet");
   chk_arb_holds: assert property (arb_request && !arb_grant |=> arb_request)
      else $error("request dropped before grant");
   chk_grant_to_data: assert property (s_granted |-> ##3 tx_valid)
      else $error("first word late after grant");
   chk_word_holds: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
      else $error("word changed before acceptance");
   chk_speed_stable: assert property (tx_valid && $past(tx_valid) |-> $stable(tx_speed) && $stable(tx_no_crc))
      else $error("packet attributes moved mid packet");
   chk_speed_legal: assert property (tx_valid |-> tx_speed != 2'h3)
      else $error("undefined speed sent");
   chk_no_arb_sending: assert property (tx_valid |-> !arb_request)
      else $error("arbitrating while streaming");
   chk_gap_after_last: assert property (s_last_taken |=> !arb_request)
      else $error("arbitration straight after last word");
   cov_last: cover property (s_last_taken ##1 !tx_valid);
endmodule

bind atq_top atq_properties #(.DEPTH(DEPTH)) chk (.clk(clk), .reset(reset), .reg_addr(reg_addr),
   .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .arb_request(arb_request),
   .arb_grant(arb_grant), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last),
   .tx_speed(tx_speed), .tx_no_crc(tx_no_crc));
`default_nettype wire
